//--- dv/nvm_ctrl_props.sv
// Port-level checks for the memory access controller
`timescale 1ns/1ps
module nvm_ctrl_props import nvm_pkg::*; (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic [7:0]  paddr,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        wdt_reset,
	input wire logic        bor_reset,
	input wire logic        code_protect,
	input wire logic        pm_rd,
	input wire logic        prg_rd,
	input wire logic [7:0]  prg_rdata,
	input wire logic        prg_denied,
	input wire logic        write_done_flag
);
	logic rd_ok;
	assign rd_ok = psel && penable && pready && !pwrite;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_ready_wait: assert property (psel && !penable |=> !pready) else $error("pready too early");
	a_ready_pulse: assert property (pready |=> !pready) else $error("pready longer than a cycle");
	a_unmapped_err: assert property (pready && paddr > 8'h18 |-> pslverr) else $error("no slave error");
	a_unlock_zero: assert property (rd_ok && paddr == OFS_UNLOCK |-> prdata == 32'h0)
		else $error("unlock port read not zero");
	a_high_data: assert property (rd_ok && paddr == OFS_DATA_HIGH |-> prdata[31:6] == 26'h0)
		else $error("data high upper bits set");
	a_high_addr: assert property (rd_ok && paddr == OFS_ADDR_HIGH |-> prdata[31:4] == 28'h0)
		else $error("address high upper bits set");
	a_fetch_once: assert property (pm_rd |=> !pm_rd) else $error("fetch longer than a cycle");
	a_fetch_stall: assert property (pm_rd && psel && penable && !pready |=> !pready) else $error("no stall in fetch");
	a_deny_sync: assert property (prg_denied == $past(code_protect, 2)) else $error("deny latency");
	a_prg_gate: assert property (prg_rd && prg_denied |=> prg_rdata == 8'h0) else $error("protected read leaked");
	a_done_hold: assert property (write_done_flag && !wdt_reset && !bor_reset
		&& !(psel && penable && pwrite && paddr == OFS_FLAGS) |=> write_done_flag) else $error("done flag lost");
	c_fetch: cover property (pm_rd);
	c_done: cover property ($rose(write_done_flag));
	c_err: cover property (pready && pslverr);
	c_deny: cover property (prg_rd && prg_denied);
endmodule // nvm_ctrl_props
bind nvm_ctrl nvm_ctrl_props u_props (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .prdata, .pready,
	.pslverr, .wdt_reset, .bor_reset, .code_protect, .pm_rd, .prg_rd, .prg_rdata, .prg_denied, .write_done_flag);

//--- dv/nvm_pm_model.sv
// Program memory model answering word fetches from the controller
`timescale 1ns/1ps
module nvm_pm_model (
	input  wire logic [nvm_pkg::PADDR_W-1:0] pm_addr,
	input  wire logic                        pm_rd,
	output logic      [nvm_pkg::PWORD_W-1:0] pm_data
);
	import nvm_pkg::*;
	logic [13:0] word;
	assign word = {pm_addr[5:0], pm_addr[11:4]} ^ 14'h2a5a;
	// Outside a fetch the bus shows the inverse, so a stale sample cannot pass
	assign pm_data = pm_rd ? word : ~word;
endmodule // nvm_pm_model

//--- dv/tb_eeprom_flash_access_controller.sv
// Register-level testbench for the memory access controller
`timescale 1ns/1ps
module tb_eeprom_flash_access_controller;
	import nvm_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, wdt_reset, code_protect;
	logic        pm_rd, prg_rd, prg_denied, write_done_flag, rerr;
	logic [7:0]  paddr, prg_addr, prg_rdata;
	logic [31:0] pwdata, prdata, rdat;
	logic [11:0] pm_addr;
	logic [13:0] pm_data;
	int          err_total, compares;
	nvm_ctrl #(.WRITE_CYCLES(40)) dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.external_reset_pin_n(1'b1), .wdt_reset(wdt_reset), .bor_reset(1'b0), .code_protect(code_protect),
		.pm_addr(pm_addr), .pm_rd(pm_rd), .pm_data(pm_data), .prg_rd(prg_rd), .prg_addr(prg_addr),
		.prg_rdata(prg_rdata), .prg_denied(prg_denied), .write_done_flag(write_done_flag));
	nvm_pm_model pm_u (.pm_addr(pm_addr), .pm_rd(pm_rd), .pm_data(pm_data));
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	task automatic summarize();
		$display("Compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			err_total++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rdat = prdata;
		rerr = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		if (n == 20) chk("pready", 32'h1, 32'h0);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
		apb(1'b0, a, 32'h0);
		chk(nm, e, rdat);
	endtask
	task automatic unlock(input logic [31:0] c);
		wr(OFS_UNLOCK, {24'h0, KEY_FIRST});
		wr(OFS_UNLOCK, {24'h0, KEY_SECOND});
		wr(OFS_CONTROL, c);
	endtask
	task automatic settle();
		int n;
		n = 0;
		do begin
			apb(1'b0, OFS_CONTROL, 32'h0);
			n++;
		end while (rdat[CTL_WR] !== 1'b0 && n < 40);
	endtask
	task automatic prog(input logic [7:0] e);
		@(posedge pclk);
		prg_addr <= 8'hff;
		prg_rd   <= 1'b1;
		@(posedge pclk);
		prg_rd <= 1'b0;
		@(posedge pclk);
		chk("programmer data", {24'h0, e}, {24'h0, prg_rdata});
	endtask
	initial begin
		#(25ns * 8000);
		chk("watchdog", 32'h1, 32'h0);
		summarize();
	end
	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite, wdt_reset, code_protect, prg_rd} = 6'h0;
		{paddr, prg_addr, pwdata} = 48'h0;
		err_total = 0;
		compares = 0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 7; i++) rd(8'(4 * i), 32'h0, "reset value");
		rd(8'h1c, 32'h0, "unmapped read");
		chk("slave error", 32'h1, {31'h0, rerr});
		wr(OFS_DATA_HIGH, 32'hff);
		rd(OFS_DATA_HIGH, 32'h3f, "data high");
		wr(OFS_ADDR_HIGH, 32'hff);
		rd(OFS_ADDR_HIGH, 32'h0f, "address high");
		wr(OFS_ADDR_LOW, 32'hff);
		wr(OFS_DATA_BYTE, 32'ha5);
		unlock(32'h06);
		rd(OFS_CONTROL, 32'h04, "permit not yet set");
		wr(OFS_CONTROL, 32'h06);
		rd(OFS_CONTROL, 32'h04, "no keys");
		wr(OFS_UNLOCK, 32'h55);
		wr(OFS_DATA_BYTE, 32'ha5);
		wr(OFS_UNLOCK, 32'haa);
		wr(OFS_CONTROL, 32'h06);
		rd(OFS_CONTROL, 32'h04, "broken sequence");
		unlock(32'h06);
		rd(OFS_CONTROL, 32'h06, "write started");
		wr(OFS_CONTROL, 32'h00);
		rd(OFS_CONTROL, 32'h02, "permit cleared");
		settle();
		rd(OFS_FLAGS, 32'h80, "done flag");
		chk("done flag port", 32'h1, {31'h0, write_done_flag});
		rd(OFS_CONTROL, 32'h00, "write finished");
		wr(OFS_DATA_BYTE, 32'h00);
		wr(OFS_CONTROL, 32'h01);
		rd(OFS_DATA_BYTE, 32'ha5, "top cell");
		rd(OFS_CONTROL, 32'h00, "read strobe");
		wr(OFS_FLAGS, 32'h80);
		rd(OFS_FLAGS, 32'h80, "flag set write");
		wr(OFS_FLAGS, 32'h00);
		rd(OFS_FLAGS, 32'h00, "flag cleared");
		wr(OFS_CONTROL, 32'h04);
		unlock(32'h86);
		rd(OFS_CONTROL, 32'h84, "program select");
		repeat (50) @(posedge pclk);
		rd(OFS_FLAGS, 32'h00, "no program write");
		wr(OFS_ADDR_HIGH, 32'h0a);
		wr(OFS_ADDR_LOW, 32'h3c);
		wr(OFS_CONTROL, 32'h81);
		rd(OFS_DATA_BYTE, 32'hf9, "program low");
		rd(OFS_DATA_HIGH, 32'h16, "program high");
		wr(OFS_ADDR_LOW, 32'h07);
		wr(OFS_DATA_BYTE, 32'h3c);
		wr(OFS_CONTROL, 32'h04);
		unlock(32'h06);
		@(posedge pclk);
		wdt_reset <= 1'b1;
		@(posedge pclk);
		wdt_reset <= 1'b0;
		rd(OFS_CONTROL, 32'h08, "aborted write");
		rd(OFS_ADDR_LOW, 32'h07, "address kept");
		rd(OFS_DATA_BYTE, 32'h3c, "data kept");
		wr(OFS_CONTROL, 32'h01);
		rd(OFS_DATA_BYTE, 32'hff, "erased cell");
		prog(8'ha5);
		code_protect <= 1'b1;
		repeat (4) @(posedge pclk);
		chk("denied", 32'h1, {31'h0, prg_denied});
		prog(8'h00);
		wr(OFS_ADDR_LOW, 32'hff);
		wr(OFS_CONTROL, 32'h01);
		rd(OFS_DATA_BYTE, 32'ha5, "protected cpu read");
		summarize();
	end
endmodule // tb_eeprom_flash_access_controller

//--- rtl/nvm_ctrl.sv
// APB-facing controller for data array and program memory access
`timescale 1ns/1ps
module nvm_ctrl #(
	parameter int WRITE_CYCLES = nvm_pkg::WRITE_CYCLES
) (
	input  wire logic                         pclk,
	input  wire logic                         presetn,
	input  wire logic [7:0]                   paddr,
	input  wire logic                         psel,
	input  wire logic                         penable,
	input  wire logic                         pwrite,
	input  wire logic [31:0]                  pwdata,
	output logic      [31:0]                  prdata,
	output logic                              pready,
	output logic                              pslverr,
	input  wire logic                         external_reset_pin_n,
	input  wire logic                         wdt_reset,
	input  wire logic                         bor_reset,
	input  wire logic                         code_protect,
	output logic      [nvm_pkg::PADDR_W-1:0]  pm_addr,
	output logic                              pm_rd,
	input  wire logic [nvm_pkg::PWORD_W-1:0]  pm_data,
	input  wire logic                         prg_rd,
	input  wire logic [nvm_pkg::DADDR_W-1:0]  prg_addr,
	output logic      [7:0]                   prg_rdata,
	output logic                              prg_denied,
	output logic                              write_done_flag
);
	import nvm_pkg::*;

	nvm_link_if link ();

	nvm_data_array #(
		.WRITE_CYCLES (WRITE_CYCLES)
	) u_array (
		.pclk    (pclk),
		.presetn (presetn),
		.link    (link)
	);

	logic [7:0]         data_byte_reg;
	logic [DADDR_W-1:0] address_low_reg;
	logic [DHIGH_W-1:0] data_high_reg;
	logic [AHIGH_W-1:0] address_high_reg;
	logic               memory_space_select;
	logic               write_permit;
	logic               write_abort_flag;
	logic               wr_strobe;
	nvm_rd_e            rd_st;
	nvm_unlock_e        ul_st;
	logic               ext_meta;
	logic               ext_sync;
	logic               cp_meta;
	logic               cp_sync;
	logic               warm;
	logic               ready_q;
	logic               wr_fire;
	logic               ctl_wr;
	logic               start;
	logic               hit;
	logic [7:0]         rd_mux;

	// External reset and protect strap come from pins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_meta <= 1'b1;
			ext_sync <= 1'b1;
			cp_meta  <= 1'b0;
			cp_sync  <= 1'b0;
		end else begin
			ext_meta <= external_reset_pin_n;
			ext_sync <= ext_meta;
			cp_meta  <= code_protect;
			cp_sync  <= cp_meta;
		end
	end

	assign warm = !ext_sync || wdt_reset || bor_reset;

	// One wait state per access; the fetch cycle adds another
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ready_q <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= '0;
		end else begin
			ready_q <= psel && penable && !ready_q && rd_st != NVM_RD_PM_FETCH;
			if (psel && penable && !ready_q) begin
				pslverr <= !hit;
				prdata  <= {24'h000000, rd_mux};
			end
		end
	end

	assign pready  = ready_q;
	assign wr_fire = psel && penable && pwrite && ready_q;
	assign ctl_wr  = wr_fire && paddr == OFS_CONTROL;

	always_comb begin
		hit    = 1'b1;
		rd_mux = 8'h00;
		if (paddr == OFS_DATA_BYTE) begin
			rd_mux = data_byte_reg;
		end else if (paddr == OFS_ADDR_LOW) begin
			rd_mux = address_low_reg;
		end else if (paddr == OFS_DATA_HIGH) begin
			rd_mux = {2'b00, data_high_reg};
		end else if (paddr == OFS_ADDR_HIGH) begin
			rd_mux = {4'h0, address_high_reg};
		end else if (paddr == OFS_CONTROL) begin
			rd_mux[CTL_SEL]  = memory_space_select;
			rd_mux[CTL_ERR]  = write_abort_flag;
			rd_mux[CTL_WRITE_PERMIT] = write_permit;
			rd_mux[CTL_WR]   = wr_strobe;
			rd_mux[CTL_RD]   = rd_st != NVM_RD_IDLE;
		end else if (paddr == OFS_UNLOCK) begin
			rd_mux = 8'h00;
		end else if (paddr == OFS_FLAGS) begin
			rd_mux[FLG_DONE] = write_done_flag;
		end else begin
			hit = 1'b0;
		end
	end

	// Select written together with the strobe takes effect for it; permit must already be set
	assign start = ctl_wr && pwdata[CTL_WR] && ul_st == NVM_UL_ARMED && write_permit
		&& !pwdata[CTL_SEL] && !wr_strobe && !warm;

	assign link.start    = start;
	assign link.abort    = warm && wr_strobe;
	assign link.addr     = address_low_reg;
	assign link.wdata    = data_byte_reg;
	assign link.rd_addr  = address_low_reg;
	assign link.prg_addr = prg_addr;

	// Data and address registers ignore warm resets so a retry is possible
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			address_low_reg  <= RST_BYTE;
			address_high_reg <= '0;
		end else if (wr_fire) begin
			if (paddr == OFS_ADDR_LOW) begin
				address_low_reg <= pwdata[7:0];
			end
			if (paddr == OFS_ADDR_HIGH) begin
				address_high_reg <= pwdata[AHIGH_W-1:0];
			end
		end
	end

	assign pm_addr = {address_high_reg, address_low_reg};
	assign pm_rd   = rd_st == NVM_RD_PM_FETCH;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			data_byte_reg <= RST_BYTE;
			data_high_reg <= '0;
		end else if (rd_st == NVM_RD_PM_FETCH) begin
			data_byte_reg <= pm_data[7:0];
			data_high_reg <= pm_data[PWORD_W-1:8];
		end else if (rd_st == NVM_RD_DATA) begin
			data_byte_reg <= link.rdata;
		end else if (wr_fire) begin
			if (paddr == OFS_DATA_BYTE) begin
				data_byte_reg <= pwdata[7:0];
			end
			if (paddr == OFS_DATA_HIGH) begin
				data_high_reg <= pwdata[DHIGH_W-1:0];
			end
		end
	end

	// Read strobe: set-only by software, state returns to idle when done
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_st <= NVM_RD_IDLE;
		end else if (warm) begin
			rd_st <= NVM_RD_IDLE;
		end else begin
			case (rd_st)
				NVM_RD_IDLE: begin
					if (ctl_wr && pwdata[CTL_RD]) begin
						rd_st <= pwdata[CTL_SEL] ? NVM_RD_PM_WAIT : NVM_RD_DATA;
					end
				end
				NVM_RD_PM_WAIT: begin
					rd_st <= NVM_RD_PM_FETCH;
				end
				default: begin
					rd_st <= NVM_RD_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			memory_space_select <= 1'b0;
			write_permit        <= 1'b0;
		end else if (warm) begin
			memory_space_select <= 1'b0;
			write_permit        <= 1'b0;
		end else if (ctl_wr) begin
			memory_space_select <= pwdata[CTL_SEL];
			write_permit        <= pwdata[CTL_WRITE_PERMIT];
		end
	end

	// A zero written to the strobe is ignored; only the timer or a warm reset ends it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_strobe <= 1'b0;
		end else if (warm || link.done) begin
			wr_strobe <= 1'b0;
		end else if (start) begin
			wr_strobe <= 1'b1;
		end
	end

	// Abort sets win over any software write in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			write_abort_flag <= 1'b0;
		end else if (warm && wr_strobe) begin
			write_abort_flag <= 1'b1;
		end else if (link.done) begin
			write_abort_flag <= 1'b0;
		end else if (ctl_wr) begin
			write_abort_flag <= pwdata[CTL_ERR];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			write_done_flag <= 1'b0;
		end else if (link.done) begin
			write_done_flag <= 1'b1;
		end else if (wr_fire && paddr == OFS_FLAGS && !pwdata[FLG_DONE]) begin
			write_done_flag <= 1'b0;
		end
	end

	// Every register write other than the expected next step disarms
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ul_st <= NVM_UL_IDLE;
		end else if (warm) begin
			ul_st <= NVM_UL_IDLE;
		end else if (wr_fire) begin
			if (paddr == OFS_UNLOCK && pwdata[7:0] == KEY_FIRST) begin
				ul_st <= NVM_UL_KEY1;
			end else if (paddr == OFS_UNLOCK && pwdata[7:0] == KEY_SECOND && ul_st == NVM_UL_KEY1) begin
				ul_st <= NVM_UL_ARMED;
			end else begin
				ul_st <= NVM_UL_IDLE;
			end
		end
	end

	// Programmer port sees nothing while protection is on
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prg_rdata <= RST_BYTE;
		end else if (prg_rd) begin
			prg_rdata <= cp_sync ? RST_BYTE : link.prg_rdata;
		end
	end

	assign prg_denied = cp_sync;
endmodule // nvm_ctrl

//--- rtl/nvm_data_array.sv
// Data byte array with erase-before-write and on-chip write timer
`timescale 1ns/1ps
module nvm_data_array #(
	parameter int WRITE_CYCLES = nvm_pkg::WRITE_CYCLES
) (
	input  wire logic  pclk,
	input  wire logic  presetn,
	nvm_link_if.array  link
);
	import nvm_pkg::*;

	logic [7:0]       mem [DATA_DEPTH];
	logic [7:0]       wr_addr;
	logic [7:0]       wr_data;
	logic [TMR_W-1:0] tmr;
	logic             busy;
	logic             take;

	assign take       = link.start && !busy;
	assign link.busy  = busy;
	assign link.done  = busy && (tmr == '0) && !link.abort;
	assign link.rdata = mem[link.rd_addr];
	assign link.prg_rdata = mem[link.prg_addr];

	// Write duration counted here, software only sees busy and done
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy    <= 1'b0;
			tmr     <= '0;
			wr_addr <= RST_BYTE;
			wr_data <= RST_BYTE;
		end else if (link.abort) begin
			busy <= 1'b0;
		end else if (take) begin
			busy    <= 1'b1;
			tmr     <= TMR_W'(WRITE_CYCLES - 1);
			wr_addr <= link.addr;
			wr_data <= link.wdata;
		end else if (busy) begin
			if (tmr == '0) begin
				busy <= 1'b0;
			end else begin
				tmr <= tmr - 1'b1;
			end
		end
	end

	// An aborted cell is left erased, so a retry rewrites it fully
	for (genvar i = 0; i < DATA_DEPTH; i++) begin : g_cell
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				mem[i] <= ERASED;
			end else if (take && link.addr == 8'(i)) begin
				mem[i] <= ERASED;
			end else if (link.done && wr_addr == 8'(i)) begin
				mem[i] <= wr_data;
			end
		end
	end
endmodule // nvm_data_array

//--- rtl/nvm_link_if.sv
// Link between the controller and the data array with its write timer
`timescale 1ns/1ps
interface nvm_link_if;
	logic       start;
	logic       abort;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic [7:0] rd_addr;
	logic [7:0] rdata;
	logic [7:0] prg_addr;
	logic [7:0] prg_rdata;
	logic       busy;
	logic       done;
	modport ctrl  (output start, abort, addr, wdata, rd_addr, prg_addr, input rdata, prg_rdata, busy, done);
	modport array (input start, abort, addr, wdata, rd_addr, prg_addr, output rdata, prg_rdata, busy, done);
endinterface

//--- rtl/nvm_pkg.sv
// Shared constants and types for the non-volatile memory access controller
package nvm_pkg;
	localparam int CLK_MHZ       = 40;
	localparam int WRITE_TIME_US = 5000;
	localparam int WRITE_CYCLES  = WRITE_TIME_US * CLK_MHZ;
	localparam int TMR_W         = 18;
	localparam int DATA_DEPTH    = 256;
	localparam int DADDR_W       = 8;
	localparam int PADDR_W       = 12;
	localparam int PWORD_W       = 14;
	localparam int DHIGH_W       = 6;
	localparam int AHIGH_W       = 4;

	localparam logic [7:0] OFS_DATA_BYTE = 8'h00;
	localparam logic [7:0] OFS_ADDR_LOW  = 8'h04;
	localparam logic [7:0] OFS_DATA_HIGH = 8'h08;
	localparam logic [7:0] OFS_ADDR_HIGH = 8'h0c;
	localparam logic [7:0] OFS_CONTROL   = 8'h10;
	localparam logic [7:0] OFS_UNLOCK    = 8'h14;
	localparam logic [7:0] OFS_FLAGS     = 8'h18;

	localparam int CTL_RD   = 0;
	localparam int CTL_WR   = 1;
	localparam int CTL_WRITE_PERMIT = 2;
	localparam int CTL_ERR  = 3;
	localparam int CTL_SEL  = 7;
	localparam int FLG_DONE = 7;

	localparam logic [7:0] KEY_FIRST  = 8'h55;
	localparam logic [7:0] KEY_SECOND = 8'haa;
	localparam logic [7:0] ERASED     = 8'hff;
	localparam logic [7:0] RST_BYTE   = 8'h00;

	typedef enum {NVM_RD_IDLE, NVM_RD_DATA, NVM_RD_PM_WAIT, NVM_RD_PM_FETCH} nvm_rd_e;
	typedef enum {NVM_UL_IDLE, NVM_UL_KEY1, NVM_UL_ARMED} nvm_unlock_e;
endpackage
